// [shared/wsw_pkg.sv]
/*
  Shared constants and carrier types for the window/standard watchdog.
  Assumes a single 20 MHz clock and synchronous pin inputs other than the kick.
*/
// Behaviour
// - With power good high, low guard-off enables the watchdog, high disables it.
// - With power good low, watchdog disabled and fault pin released.
// - Power good rising while enabled starts an initialization.
// - Guard-off falling while power good high starts an initialization.
// - Fault output returning high while enabled starts an initialization.
// - Initialization open window lasts eight guard periods awaiting the first kick.
// - Guard type select low gives window mode, high gives standard mode.
// - Window mode: kick in initialization window restarts counter, opens closed window.
// - Window mode: kick edge in closed window gives one fault pulse.
// - Open window without kick faults after half a guard period, or after eight ninths of one in 8:1 window mode.
// - Initialization without kick faults after eight guard periods.
// - Standard mode: kick in open window restarts counter and a new open window.
// - Fault pin stays released while service is proper.
// - Fault pulls the pin low for one fifth of a guard period.
// - Window ratio select low splits 1:1, high splits open:closed 8:1.
// - Period range select high makes the guard period five times longer.
package wsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_FREQ_MHZ    = 20;
  localparam int unsigned GUARD_PERIOD_US = 10000;   // Low-range period
  localparam int unsigned GUARD_CYCLES    = GUARD_PERIOD_US * CLK_FREQ_MHZ;
  localparam int unsigned KICK_MIN_US     = 100;
  localparam int unsigned KICK_MIN_CYCLES = KICK_MIN_US * CLK_FREQ_MHZ;
  localparam int unsigned CNT_W           = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Window arithmetic factors
  localparam int unsigned RANGE_MULT = 5;  // Period range high
  localparam int unsigned INIT_MULT  = 8;  // Initialization window
  localparam int unsigned HALF_DIV   = 2;  // 1:1 split
  localparam int unsigned RATIO_DIV  = 9;  // 8:1 split, closed part
  localparam int unsigned HOLD_DIV   = 5;  // Fault hold, 20 percent

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    WSW_IDLE,
    WSW_INIT,
    WSW_OPEN,
    WSW_CLOSED,
    WSW_FAULT
  } wsw_state_e;

  typedef struct packed {
    logic armed;       // Watchdog enabled
    logic init_win;    // In initialization window
    logic closed_win;  // In closed window
    logic line_high;   // Sampled fault pin level
  } wsw_stat_s;

  localparam wsw_stat_s STAT_RESET = '0;

endpackage : wsw_pkg

// [design/wsw_kick_sync.sv]
/*
  Kick input synchroniser and rising-edge detector.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module wsw_kick_sync
  import wsw_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic kick_in,
  output logic      kick_rise_out
);

  logic sync_a;
  logic sync_b;
  logic sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sync_a <= kick_in;
      sync_b <= sync_a;
      sync_q <= sync_b;
    end
  end

  // Edge pulse from settled stages only
  assign kick_rise_out = sync_b & ~sync_q;

  a_kick_one_pulse: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    kick_rise_out |=> !kick_rise_out
  ) else $error("kick edge pulse lasted more than one cycle");

  // Pulse only after the kick has crossed both stages
  a_kick_sync_depth: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    kick_rise_out |-> $past(kick_in, 2)
  ) else $error("kick edge pulse without a kick two cycles earlier");

endmodule : wsw_kick_sync

// [design/wsw_core.sv]
/*
  Window/standard watchdog supervisor core.
  Assumes pin inputs synchronous to clk_in except the kick, which is
  synchronised here; the fault pin is open drain with an external pull-up.
*/
`timescale 1ns/100ps
module wsw_core
  import wsw_pkg::*;
#(
  parameter logic [CNT_W-1:0] BASE_CYCLES = CNT_W'(GUARD_CYCLES)
)
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic power_good_in,
  input  wire logic guard_off_request_in,
  input  wire logic guard_type_select_in,
  input  wire logic window_ratio_select_in,
  input  wire logic period_range_select_in,
  input  wire logic kick_in,
  input  wire logic service_fault_in,
  output logic      service_fault_out,
  output logic      service_fault_oe_out,
  output wsw_stat_s status_out
);

  wsw_state_e       state;
  logic [CNT_W-1:0] cnt;
  logic             en;
  logic             en_q;
  logic             start_init;
  logic             kick;
  logic             win_mode;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] lim_init;
  logic [CNT_W-1:0] lim_open;
  logic [CNT_W-1:0] lim_closed;
  logic [CNT_W-1:0] lim_hold;
  logic [CNT_W-1:0] cur_lim;
  logic             tick_end;
  logic             restart;

  ////////////////////////////////////////////////////////////////////////////
  // Kick edge detection
  wsw_kick_sync wsw_kick_sync_inst (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .kick_in       (kick_in),
    .kick_rise_out (kick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Enable and initialization triggers
  assign en       = power_good_in & ~guard_off_request_in;
  assign win_mode = ~guard_type_select_in;

  // Enable edge covers both power good rising and guard-off falling
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en;
    end
  end

  assign start_init = en & ~en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Window durations in clock cycles
  // Base must be at least 9 cycles so no window rounds to zero
  always_comb begin
    period = BASE_CYCLES;
    if (period_range_select_in) begin
      period = CNT_W'(BASE_CYCLES * RANGE_MULT);
    end
    lim_init = CNT_W'(period * INIT_MULT);
    lim_hold = CNT_W'(period / HOLD_DIV);
    // Standard mode has no closed window and a half-period open window
    if (win_mode && window_ratio_select_in) begin
      lim_closed = CNT_W'(period / RATIO_DIV);
      lim_open   = period - lim_closed;
    end else begin
      lim_closed = CNT_W'(period / HALF_DIV);
      lim_open   = CNT_W'(period / HALF_DIV);
    end
  end

  // Limit of the window currently being timed
  always_comb begin
    case (state)
      WSW_INIT:   cur_lim = lim_init;
      WSW_OPEN:   cur_lim = lim_open;
      WSW_CLOSED: cur_lim = lim_closed;
      WSW_FAULT:  cur_lim = lim_hold;
      default:    cur_lim = lim_init;
    endcase
  end

  assign tick_end = (cnt == cur_lim - CNT_W'(1));

  // Any window change or accepted kick restarts the count
  assign restart = start_init
                 | ((state != WSW_IDLE) & tick_end)
                 | ((state != WSW_IDLE) & (state != WSW_FAULT) & kick);

  ////////////////////////////////////////////////////////////////////////////
  // Window counter
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= '0;
    end else if (!en || restart) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sequencing
  // Disable wins over every event; a fresh enable always reinitializes
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= WSW_IDLE;
    end else if (!en) begin
      state <= WSW_IDLE;
    end else if (start_init) begin
      state <= WSW_INIT;
    end else begin
      case (state)
        WSW_INIT: begin
          if (kick) begin
            state <= win_mode ? WSW_CLOSED : WSW_OPEN;
          end else if (tick_end) begin
            state <= WSW_FAULT;
          end
        end
        WSW_OPEN: begin
          if (kick) begin
            state <= win_mode ? WSW_CLOSED : WSW_OPEN;
          end else if (tick_end) begin
            state <= WSW_FAULT;
          end
        end
        WSW_CLOSED: begin
          if (kick) begin
            state <= WSW_FAULT;
          end else if (tick_end) begin
            state <= WSW_OPEN;
          end
        end
        WSW_FAULT: begin
          // Kicks during the hold are ignored; release reinitializes
          if (tick_end) begin
            state <= WSW_INIT;
          end
        end
        default: begin
          state <= WSW_INIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain fault pin: drive low only during the hold
  assign service_fault_out    = 1'b0;
  assign service_fault_oe_out = (state == WSW_FAULT);

  // Status flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_out <= STAT_RESET;
    end else begin
      status_out.armed      <= en;
      status_out.init_win   <= (state == WSW_INIT);
      status_out.closed_win <= (state == WSW_CLOSED);
      status_out.line_high  <= service_fault_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic [CNT_W-1:0] hold_len;

  // Length of the current low pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_len <= '0;
    end else if (service_fault_oe_out) begin
      hold_len <= hold_len + CNT_W'(1);
    end else begin
      hold_len <= '0;
    end
  end

  a_pg_low_released: assert property (
    !power_good_in |=> !service_fault_oe_out && state == WSW_IDLE
  ) else $error("fault pin driven while power good low");

  a_off_disables: assert property (
    guard_off_request_in |=> state == WSW_IDLE
  ) else $error("watchdog not disabled by guard-off request");

  a_enable_inits: assert property (
    (en && !en_q) |=> state == WSW_INIT && cnt == '0
  ) else $error("enable edge did not start initialization");

  a_hold_length: assert property (
    ($fell(service_fault_oe_out) && $past(en) && en && !$past(start_init))
      |-> hold_len == $past(lim_hold)
  ) else $error("fault hold length wrong");

  a_release_reinit: assert property (
    ($fell(service_fault_oe_out) && $past(en) && en) |-> state == WSW_INIT
  ) else $error("fault release did not reinitialize");

  a_closed_kick_fault: assert property (
    (state == WSW_CLOSED && kick && en && !start_init) |=> service_fault_oe_out
  ) else $error("kick in closed window did not fault");

  a_init_timeout: assert property (
    (state == WSW_INIT && tick_end && !kick && en && !start_init) |=> service_fault_oe_out
  ) else $error("initialization timeout did not fault");

  a_open_timeout: assert property (
    (state == WSW_OPEN && tick_end && !kick && en && !start_init) |=> service_fault_oe_out
  ) else $error("open window timeout did not fault");

  a_win_init_kick: assert property (
    (state == WSW_INIT && kick && win_mode && en && !start_init)
      |=> state == WSW_CLOSED && cnt == '0
  ) else $error("window kick did not open closed window");

  a_std_open_kick: assert property (
    (state == WSW_OPEN && kick && !win_mode && en && !start_init)
      |=> state == WSW_OPEN && cnt == '0
  ) else $error("standard kick did not restart open window");

  a_std_no_closed: assert property (
    (!win_mode && en && $stable(guard_type_select_in) && state != WSW_CLOSED)
      |=> state != WSW_CLOSED
  ) else $error("closed window entered in standard mode");

  // Long range: init window and hold both scale, the hold landing on one base period
  a_range_period: assert property (
    period_range_select_in |-> lim_init == CNT_W'(BASE_CYCLES * RANGE_MULT * INIT_MULT)
                               && lim_hold == BASE_CYCLES
  ) else $error("range select did not scale period");

endmodule : wsw_core

// [bench/wsw_host_model.sv]
/*
  Host side model: a microcontroller kicking the watchdog, plus the fault wire pull-up.
  Assumes kick requests are raised just after a rising edge of clk_in.
*/
`timescale 1ns/100ps
module wsw_host_model #(
  parameter int HIGH_CYC = 4  // Kick width, shortened like the guard period
)
(
  input  wire logic clk_in,
  input  wire logic kick_req_in,
  input  wire logic fault_oe_in,
  input  wire logic fault_data_in,
  output logic      kick_out,
  output logic      fault_wire_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Kick: rise after the edge that sees a request, hold, then drop
  // One process owns the kick, so it is low from time zero
  initial begin
    kick_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (kick_req_in === 1'b1) begin
        #2 kick_out = 1'b1;
        repeat (HIGH_CYC) @(posedge clk_in);
        #2 kick_out = 1'b0;
      end
    end
  end

  // Open drain with pull-up, so a released wire reads high
  assign fault_wire_out = fault_oe_in ? fault_data_in : 1'b1;
endmodule : wsw_host_model

// [bench/test_window_standard_watchdog.sv]
/*
  Self-checking bench for the watchdog core, timing measured in clock edges.
  Assumes the host model drives the kick and resolves the fault wire.
*/
`timescale 1ns/100ps
module test_window_standard_watchdog
  import wsw_pkg::*;
;
  localparam int unsigned BASE = 90;  // Short guard period keeps the run brief
  localparam int unsigned INI  = INIT_MULT * BASE;
  localparam int unsigned HALF = BASE / HALF_DIV;
  localparam int unsigned CW81 = BASE / RATIO_DIV;
  localparam int unsigned HOLD = BASE / HOLD_DIV;
  logic      clk_in, nrst_in, pg, goff, gtype, ratio, range, kick_req, seen_oe;
  logic      kick, wire_lvl, f_out, f_oe;
  wsw_stat_s stat;
  int        error_cnt = 0;
  int        n_compared = 0;

  ////////////////////////////////////////////////////////////////////////////
  wsw_core #(.BASE_CYCLES(CNT_W'(BASE))) wsw_core_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .power_good_in(pg), .guard_off_request_in(goff),
    .guard_type_select_in(gtype), .window_ratio_select_in(ratio), .period_range_select_in(range),
    .kick_in(kick), .service_fault_in(wire_lvl), .service_fault_out(f_out),
    .service_fault_oe_out(f_oe), .status_out(stat));
  wsw_host_model wsw_host_model_inst (
    .clk_in(clk_in), .kick_req_in(kick_req), .fault_oe_in(f_oe), .fault_data_in(f_out),
    .kick_out(kick), .fault_wire_out(wire_lvl));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Inputs move 2 ns after the edge; a kick request lasts one edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #2;
      // Clear only a pending request, so a new one is the sole write of its step
      if (kick_req) begin
        kick_req = 1'b0;
      end
      // Sticky flag: any fault drive inside a served stretch
      if (f_oe === 1'b1) begin
        seen_oe = 1'b1;
      end
    end
  endtask : step

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_cnt(input string name, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  // Edges until the fault drive reaches lvl; bounded so a hang still reports
  task automatic meas(input string name, input logic lvl, input int exp);
    int n;
    n = 0;
    while (f_oe !== lvl) begin
      step(1);
      n++;
      if (n > 5000) begin
        error_cnt++;
        complete_run();
      end
    end
    chk_cnt(name, exp, n);
  endtask : meas

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst_in, pg, goff, gtype, ratio, range, kick_req, seen_oe} = 8'h20;
    step(2);
    nrst_in = 1'b1;
    // Guard off requested: stays disabled
    pg = 1'b1;
    step(20);
    chk_bit("armed", 1'b0, stat.armed);
    chk_bit("fault oe", 1'b0, f_oe);
    // Enable without kicks: init timeout, hold, re-init at hold end
    goff = 1'b0;
    meas("init fault", 1'b1, INI + 1);
    chk_bit("fault wire", 1'b0, wire_lvl);
    meas("fault hold", 1'b0, HOLD);
    meas("reinit fault", 1'b1, INI);
    meas("fault hold", 1'b0, HOLD);
    // Window 1:1, second kick lands in the closed window
    kick_req = 1'b1;
    step(20);
    chk_bit("closed window", 1'b1, stat.closed_win);
    kick_req = 1'b1;
    meas("closed kick", 1'b1, 4);
    meas("fault hold", 1'b0, HOLD);
    // Window 8:1, kicks early in each open window, then silence
    ratio = 1'b1;
    seen_oe = 1'b0;
    for (int i = 0; i < 8; i++) begin
      kick_req = 1'b1;
      step(CW81 + 20);
    end
    chk_bit("served", 1'b0, seen_oe);
    kick_req = 1'b1;
    meas("open fault", 1'b1, 4 + BASE);
    meas("fault hold", 1'b0, HOLD);
    // Standard mode: quick second kick is legal, then open timeout
    gtype = 1'b1;
    ratio = 1'b0;
    seen_oe = 1'b0;
    kick_req = 1'b1;
    step(5);
    kick_req = 1'b1;
    step(20);
    chk_bit("no closed window", 1'b0, seen_oe);
    kick_req = 1'b1;
    meas("std open fault", 1'b1, 4 + HALF);
    meas("fault hold", 1'b0, HOLD);
    // Long range: all figures five times longer
    range = 1'b1;
    kick_req = 1'b1;
    meas("long open fault", 1'b1, 4 + RANGE_MULT * BASE / HALF_DIV);
    meas("long hold", 1'b0, RANGE_MULT * HOLD);
    // Power loss in mid-hold releases the wire at once
    range = 1'b0;
    kick_req = 1'b1;
    meas("std open fault", 1'b1, 4 + HALF);
    step(3);
    pg = 1'b0;
    step(2);
    chk_bit("released", 1'b0, f_oe);
    chk_bit("wire high", 1'b1, stat.line_high);
    chk_bit("armed", 1'b0, stat.armed);
    // Power good returns while enabled: fresh initialization
    pg = 1'b1;
    step(2);
    chk_bit("init window", 1'b1, stat.init_win);
    meas("pg init fault", 1'b1, INI - 1);
    complete_run();
  end
endmodule : test_window_standard_watchdog
